// *** bdp_pkg.sv ***
// constants shared by the baseband data port design
// assumes a single 20 mhz system clock and no software registers
package bdp_pkg;
	// ****************************************
	// widths
	// ****************************************
	localparam int SAMPLE_W = 12;
	localparam int HALF_W = 6;

	// ****************************************
	// timing
	// ****************************************
	localparam int SYS_CLK_HZ = 20_000_000;
	localparam int CONV_CLK_HZ = 2_500_000; // divided converter clock shown on clock out
	localparam int CONV_HALF_CYC = SYS_CLK_HZ / (2 * CONV_CLK_HZ);
	localparam logic [3:0] CONV_HALF_LAST = 4'(CONV_HALF_CYC - 1);

	// ****************************************
	// clock output source select codes
	// ****************************************
	localparam logic [1:0] CLKOUT_SEL_REF = 2'h0;
	localparam logic [1:0] CLKOUT_SEL_XTAL = 2'h1;
	localparam logic [1:0] CLKOUT_SEL_CONV = 2'h2;

	// ****************************************
	// receive framing states
	// ****************************************
	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_WORD = 2'b01,
		RX_LOW = 2'b10
	} bdp_rx_state_t;
endpackage

// *** bdp_port.sv ***
// baseband data port: receive framing and clock, tx capture, lane muxing,
// clock output select and multi-chip sync.
// assumes every input is synchronous to i_clk_sys; pin legs resolved outside.
`timescale 1ns/1ps
module bdp_port (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	// mode and control
	input wire logic i_port_direction_select,
	input wire logic i_lvds_mode,
	input wire logic [1:0] i_clkout_sel,
	input wire logic i_sync_in,
	input wire logic i_ref_clk_in,
	input wire logic i_tuned_crystal_oscillator,
	// receive samples from the converter side
	input wire logic [11:0] i_rx_sample,
	input wire logic i_rx_sample_valid,
	output logic o_rx_taken,
	// transmit samples to the converter side
	output logic [11:0] o_tx_sample,
	output logic o_tx_sample_valid,
	// receive framing and clock pins
	output logic o_rx_frame_p,
	output logic o_rx_frame_n,
	output logic o_data_clk_p,
	output logic o_data_clk_n,
	// transmit framing and return clock pins
	input wire logic i_tx_frame_p,
	input wire logic i_tx_return_clock,
	// port one lanes
	input wire logic [11:0] i_port_one_lanes,
	output logic [11:0] o_port_one_lanes,
	output logic [11:0] o_port_one_lanes_oe,
	// port zero lanes, input only in this block
	input wire logic [11:0] i_port_zero_lanes,
	// clock output pin
	output logic o_clk_out
);
	// ****************************************
	// clocks: data clock, converter divider, clock out
	// ****************************************
	logic dclk_q, dclk_d;
	logic [3:0] div_cnt_q, div_cnt_d;
	logic conv_clk_q, conv_clk_d;
	logic clk_out_q, clk_out_d;
	logic sync_prev_q;
	logic sync_rise;

	// a sync edge restarts every divider so several devices line up
	always_comb begin
		sync_rise = i_sync_in & ~sync_prev_q;
		dclk_d = i_port_direction_select ? 1'b0 : ~dclk_q;
		div_cnt_d = div_cnt_q + 4'h1;
		conv_clk_d = conv_clk_q;
		if (div_cnt_q == bdp_pkg::CONV_HALF_LAST) begin
			div_cnt_d = 4'h0;
			conv_clk_d = ~conv_clk_q;
		end
		if (sync_rise) begin
			dclk_d = 1'b0;
			div_cnt_d = 4'h0;
			conv_clk_d = 1'b0;
		end
		unique case (i_clkout_sel)
			bdp_pkg::CLKOUT_SEL_XTAL: clk_out_d = i_tuned_crystal_oscillator;
			bdp_pkg::CLKOUT_SEL_CONV: clk_out_d = conv_clk_q;
			default: clk_out_d = i_ref_clk_in; // unused code falls back to reference
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			dclk_q <= 1'b0;
			div_cnt_q <= 4'h0;
			conv_clk_q <= 1'b0;
			clk_out_q <= 1'b0;
			sync_prev_q <= 1'b0;
		end else begin
			dclk_q <= dclk_d;
			div_cnt_q <= div_cnt_d;
			conv_clk_q <= conv_clk_d;
			clk_out_q <= clk_out_d;
			sync_prev_q <= i_sync_in;
		end
	end

	// ****************************************
	// receive path
	// ****************************************
	bdp_pkg::bdp_rx_state_t st_q, st_d;
	logic [11:0] word_q, word_d;
	logic [5:0] low_q, low_d;
	logic frame_q, frame_d;
	logic taken_q, taken_d;
	logic [11:0] lanes_q, lanes_d;
	logic [11:0] oe_q, oe_d;
	logic frame_n_q, frame_n_d;
	logic dclk_n_q, dclk_n_d;

	// new data is set up while the data clock is high so the far end
	// captures it on the next rising edge with half a period of margin
	always_comb begin
		st_d = st_q;
		word_d = word_q;
		low_d = low_q;
		frame_d = frame_q;
		taken_d = 1'b0;
		if (i_port_direction_select || sync_rise) begin
			st_d = bdp_pkg::RX_IDLE;
			frame_d = 1'b0;
		end else if (dclk_q) begin
			unique case (st_q)
				bdp_pkg::RX_IDLE, bdp_pkg::RX_WORD: begin
					frame_d = i_rx_sample_valid;
					taken_d = i_rx_sample_valid;
					st_d = bdp_pkg::RX_IDLE;
					if (i_rx_sample_valid && i_lvds_mode) begin
						word_d = {6'h00, i_rx_sample[11:6]};
						low_d = i_rx_sample[5:0];
						st_d = bdp_pkg::RX_LOW;
					end else if (i_rx_sample_valid) begin
						word_d = i_rx_sample;
						st_d = bdp_pkg::RX_WORD;
					end
				end
				bdp_pkg::RX_LOW: begin
					word_d = {6'h00, low_q};
					frame_d = 1'b0;
					st_d = bdp_pkg::RX_IDLE;
				end
				default: st_d = bdp_pkg::RX_IDLE;
			endcase
		end
		// differential pairs: odd lane carries the true leg, even the complement
		for (int k = 0; k < bdp_pkg::HALF_W; k++) begin
			lanes_d[2*k+1] = i_lvds_mode ? word_d[k] : word_d[2*k+1];
			lanes_d[2*k] = i_lvds_mode ? ~word_d[k] : word_d[2*k];
		end
		oe_d = {12{i_lvds_mode | ~i_port_direction_select}};
		frame_n_d = i_lvds_mode & ~frame_d;
		dclk_n_d = i_lvds_mode & ~dclk_d;
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			st_q <= bdp_pkg::RX_IDLE;
			word_q <= 12'h000;
			low_q <= 6'h00;
			frame_q <= 1'b0;
			taken_q <= 1'b0;
			lanes_q <= 12'h000;
			oe_q <= 12'h000;
			frame_n_q <= 1'b0;
			dclk_n_q <= 1'b0;
		end else begin
			st_q <= st_d;
			word_q <= word_d;
			low_q <= low_d;
			frame_q <= frame_d;
			taken_q <= taken_d;
			lanes_q <= lanes_d;
			oe_q <= oe_d;
			frame_n_q <= frame_n_d;
			dclk_n_q <= dclk_n_d;
		end
	end

	// ****************************************
	// transmit path
	// ****************************************
	logic tclk_q, tclk_prev_q, tframe_q;
	logic [11:0] t1_q, t0_q;
	logic [5:0] hi_q, hi_d, tx_p;
	logic have_hi_q, have_hi_d;
	logic [11:0] txs_q, txs_d;
	logic txv_q, txv_d;
	logic tx_edge;

	// pins are registered together so clock, frame and data stay aligned
	always_comb begin
		tx_edge = tclk_q & ~tclk_prev_q & i_port_direction_select;
		for (int k = 0; k < bdp_pkg::HALF_W; k++) begin
			tx_p[k] = t0_q[2*k+1];
		end
		hi_d = hi_q;
		have_hi_d = have_hi_q;
		txs_d = txs_q;
		txv_d = 1'b0;
		if (!i_port_direction_select) begin
			have_hi_d = 1'b0;
		end else if (tx_edge && i_lvds_mode) begin
			// frame high marks the first half; a stray low half is dropped
			if (tframe_q) begin
				hi_d = tx_p;
				have_hi_d = 1'b1;
			end else if (have_hi_q) begin
				txs_d = {hi_q, tx_p};
				txv_d = 1'b1;
				have_hi_d = 1'b0;
			end
		end else if (tx_edge && tframe_q) begin
			txs_d = t1_q;
			txv_d = 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			tclk_q <= 1'b0;
			tclk_prev_q <= 1'b0;
			tframe_q <= 1'b0;
			t1_q <= 12'h000;
			t0_q <= 12'h000;
			hi_q <= 6'h00;
			have_hi_q <= 1'b0;
			txs_q <= 12'h000;
			txv_q <= 1'b0;
		end else begin
			tclk_q <= i_tx_return_clock;
			tclk_prev_q <= tclk_q;
			tframe_q <= i_tx_frame_p;
			t1_q <= i_port_one_lanes;
			t0_q <= i_port_zero_lanes;
			hi_q <= hi_d;
			have_hi_q <= have_hi_d;
			txs_q <= txs_d;
			txv_q <= txv_d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign o_rx_taken = taken_q;
	assign o_tx_sample = txs_q;
	assign o_tx_sample_valid = txv_q;
	assign o_rx_frame_p = frame_q;
	assign o_rx_frame_n = frame_n_q;
	assign o_data_clk_p = dclk_q;
	assign o_data_clk_n = dclk_n_q;
	assign o_port_one_lanes = lanes_q;
	assign o_port_one_lanes_oe = oe_q;
	assign o_clk_out = clk_out_q;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);

	sequence s_lvds_first;
		o_rx_taken && i_lvds_mode;
	endsequence
	sequence s_rx_quiet;
		(!i_port_direction_select && i_lvds_mode && !i_sync_in)[*2];
	endsequence

	chk_taken_framed: assert property (o_rx_taken |-> o_rx_frame_p)
		else $error("sample taken without frame high");
	chk_dclk_runs: assert property (!i_port_direction_select && !sync_rise |=> o_data_clk_p != $past(o_data_clk_p))
		else $error("receive data clock not toggling");
	chk_tx_dir_release: assert property (i_port_direction_select && !i_lvds_mode |=> o_port_one_lanes_oe == 12'h000)
		else $error("port one driven in transmit direction");
	chk_rx_dir_drive: assert property (!i_port_direction_select |=> o_port_one_lanes_oe == 12'hfff)
		else $error("port one not driven in receive direction");
	chk_lvds_low_half: assert property (s_lvds_first ##0 s_rx_quiet |=> !o_rx_frame_p)
		else $error("second half not sent with frame low");
	chk_neg_legs_idle: assert property (!i_lvds_mode |=> !o_rx_frame_n && !o_data_clk_n)
		else $error("negative leg active in single-ended mode");
	chk_tx_frame_gate: assert property (tx_edge && !tframe_q && !i_lvds_mode |=> !o_tx_sample_valid)
		else $error("transmit sample taken outside frame");
	chk_clkout_ref: assert property (i_clkout_sel == bdp_pkg::CLKOUT_SEL_REF |=> o_clk_out == $past(i_ref_clk_in))
		else $error("clock out not following reference");
	chk_sync_align: assert property (sync_rise |=> div_cnt_q == 4'h0 && !o_data_clk_p)
		else $error("sync did not restart dividers");
	chk_tx_on_edge: assert property (o_tx_sample_valid |-> $past(tx_edge))
		else $error("transmit sample not on return clock edge");
	chk_tx_lvds_join: assert property (tx_edge && i_lvds_mode && !tframe_q && have_hi_q
		|=> o_tx_sample_valid && o_tx_sample[5:0] == $past(tx_p))
		else $error("differential transmit halves not joined");
endmodule

// *** bdp_bbp_model.sv ***
// baseband processor model: transmit frame, return clock and lanes
// assumes the bench resolves the two-way lanes from both enables
`timescale 1ns/1ps
module bdp_baseband_processor_model (
	// clock
	input wire logic i_clk_sys,
	// pins toward the port
	output logic o_tx_frame_p,
	output logic o_tx_return_clock,
	output logic [11:0] o_lanes,
	output logic o_lanes_oe
);
	// ****************
	// transfer
	// ****************
	// return clock stands low outside transfers
	initial begin
		o_tx_frame_p = 1'b0;
		o_tx_return_clock = 1'b0;
		o_lanes = 12'h000;
		o_lanes_oe = 1'b0;
	end
	// one return clock period; stale lanes turn to their inverse so they never look valid
	task automatic send(input logic frame, input logic [11:0] word, input int slow);
		@(posedge i_clk_sys);
		#1;
		o_tx_frame_p = frame;
		o_lanes = word;
		o_lanes_oe = 1'b1;
		o_tx_return_clock = 1'b1;
		repeat (1 + slow) @(posedge i_clk_sys);
		#1;
		o_tx_return_clock = 1'b0;
		o_tx_frame_p = 1'b0;
		o_lanes = ~word;
		o_lanes_oe = 1'b0;
		repeat (slow) @(posedge i_clk_sys);
	endtask
endmodule

// *** baseband_data_port_bench.sv ***
// bench for the baseband data port: rx, tx, clock out and sync
// assumes bdp_baseband_processor_model on the far side and one 20 mhz clock
`timescale 1ns/1ps
module baseband_data_port_bench;
	// ****************
	// signals
	// ****************
	logic clk = 1'b0, rst = 1'b1, dir = 1'b0, lvds = 1'b0, sync = 1'b0, refc = 1'b0, xtal = 1'b0, rx_v = 1'b0;
	logic [1:0] sel = 2'h0;
	logic [11:0] rx_w = 12'h000;
	logic taken, txv, frp, frn, dcp, dcn, tfr, trc, p_oe, cko;
	logic [11:0] txs, p1o, p1oe, p_ln, p1w;
	int seed = 84, fail_count = 0, checks_done = 0, n;
	logic [11:0] tx_q[$];
	always #25 clk = ~clk;
	// undriven lane bits show the inverse of the port's own lane output
	assign p1w = p_oe ? p_ln : p1o ^ ~p1oe;
	bdp_port i_bdp_port (.i_clk_sys(clk), .i_sys_rst(rst), .i_port_direction_select(dir), .i_lvds_mode(lvds),
		.i_clkout_sel(sel), .i_sync_in(sync), .i_ref_clk_in(refc), .i_tuned_crystal_oscillator(xtal),
		.i_rx_sample(rx_w), .i_rx_sample_valid(rx_v), .o_rx_taken(taken), .o_tx_sample(txs),
		.o_tx_sample_valid(txv), .o_rx_frame_p(frp), .o_rx_frame_n(frn), .o_data_clk_p(dcp), .o_data_clk_n(dcn),
		.i_tx_frame_p(tfr), .i_tx_return_clock(trc), .i_port_one_lanes(p1w), .o_port_one_lanes(p1o),
		.o_port_one_lanes_oe(p1oe), .i_port_zero_lanes(p_ln), .o_clk_out(cko));
	bdp_baseband_processor_model i_bdp_baseband_processor_model (.i_clk_sys(clk), .o_tx_frame_p(tfr),
		.o_tx_return_clock(trc), .o_lanes(p_ln), .o_lanes_oe(p_oe));
	// ****************
	// helpers
	// ****************
	task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic tick(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask
	// differential lanes: odd lane true leg, even lane inverted leg
	function automatic logic [11:0] enc(input logic [5:0] h);
		for (int k = 0; k < 6; k++) begin
			enc[2*k+1] = h[k];
			enc[2*k] = ~h[k];
		end
	endfunction
	task automatic rx_send(input logic [11:0] d);
		rx_w = d;
		rx_v = 1'b1;
		n = 0;
		do begin
			tick(1);
			n++;
		end while (taken !== 1'b1 && n < 8);
		rx_v = 1'b0;
		check("rx taken", 12'h1, 12'(taken));
		if (taken !== 1'b1) report_and_stop();
		check("rx frame legs", 12'h2, 12'({frp, frn}));
		check("rx clock legs", {11'h0, lvds}, 12'({dcp, dcn}));
		check("rx oe", 12'hfff, p1oe);
		check("rx lanes", lvds ? enc(d[11:6]) : d, p1o);
		if (lvds) begin
			tick(2);
			check("rx low half", enc(d[5:0]), p1o);
			check("rx low frame", 12'h1, 12'({frp, frn}));
		end
		// let an edge pass so the next request never re-raises valid in this step
		tick(1);
	endtask
	task automatic tx_send(input logic [11:0] d, input int slow);
		// queued first: a slow transfer reports its sample before the model returns
		tx_q.push_back(d);
		if (lvds) begin
			i_bdp_baseband_processor_model.send(1'b1, enc(d[11:6]), slow);
			i_bdp_baseband_processor_model.send(1'b0, enc(d[5:0]), slow);
		end else begin
			i_bdp_baseband_processor_model.send(1'b1, d, slow);
		end
	endtask
	// tx result model: every valid must match the oldest framed word
	always @(posedge clk) begin
		#1;
		if (txv === 1'b1) begin
			if (tx_q.size() == 0) check("tx unexpected", 12'h0, 12'h1);
			else check("tx sample", tx_q.pop_front(), txs);
		end
	end
	// hang guard
	initial begin
		#2_000_000;
		check("watchdog", 12'h0, 12'h1);
		report_and_stop();
	end
	// ****************
	// sequence
	// ****************
	initial begin
		tick(4);
		check("reset outputs", 12'h0, 12'({taken, txv, frp, frn, dcp, dcn, cko, |p1oe, |p1o}));
		rst = 1'b0;
		for (int m = 0; m < 2; m++) begin
			lvds = m[0];
			dir = 1'b0;
			rx_send(12'hfff);
			rx_send(12'h000);
			for (int i = 0; i < 3; i++) rx_send(12'($random(seed)));
			dir = 1'b1;
			rx_v = 1'b1;
			for (int i = 0; i < 6; i++) begin
				tick(1);
				check("rx in tx direction", 12'h0, 12'({taken, dcp}));
			end
			rx_v = 1'b0;
			check("tx oe", lvds ? 12'hfff : 12'h000, p1oe);
			for (int i = 0; i < 4; i++) tx_send(12'($random(seed)), i % 2);
			i_bdp_baseband_processor_model.send(1'b0, 12'($random(seed)), 0);
			dir = 1'b0;
			i_bdp_baseband_processor_model.send(1'b1, 12'($random(seed)), 0);
			tick(4);
			check("tx pending", 12'h0, 12'(tx_q.size()));
		end
		for (int s = 0; s < 4; s++) begin
			sel = s[1:0];
			n = 0;
			for (int i = 0; i < 17; i++) begin
				tick(1);
				if (i > 0 && s != 2) check("clk out", {11'h0, (s == 1) ? xtal : refc}, {11'h0, cko});
				if (i > 0) n += cko;
				refc = 1'($random(seed));
				xtal = 1'($random(seed));
			end
			if (s == 2) check("conv clk highs", 12'd8, n[11:0]);
		end
		lvds = 1'b0;
		rx_w = 12'($random(seed));
		rx_v = 1'b1;
		tick(8);
		check("frame held", 12'h1, 12'(frp));
		sync = 1'b1;
		n = 0;
		do begin
			tick(1);
			n++;
		end while (frp !== 1'b0 && n < 4);
		check("sync restart", 12'h0, 12'({frp, dcp}));
		sync = 1'b0;
		rx_v = 1'b0;
		tick(4);
		report_and_stop();
	end
endmodule
